// ==== include/sps_pkg.sv ====
package sps_pkg;
  // ****************************************
  // widths and counts
  // ****************************************
  localparam int unsigned SPS_N_OUT = 4;
  localparam int unsigned SPS_N_LED = 8;
  localparam logic [3:0] SPS_MIN_SATS = 4'h4;
  localparam logic [3:0] SPS_MAX_SATS = 4'h8;
  // ****************************************
  // timing
  // ****************************************
  localparam longint unsigned SPS_CLK_HZ = 100000000;
  localparam longint unsigned SPS_PERIOD_MS = 1000;
  localparam longint unsigned SPS_WIDTH_MS = 200;
  localparam longint unsigned SPS_COMM_HZ = 250000;
  localparam longint unsigned SPS_INIT_S = 10800;
  localparam longint unsigned SPS_FLASH_MS = 250;
  localparam longint unsigned SPS_PERIOD_CYC = SPS_CLK_HZ * SPS_PERIOD_MS / 1000;
  localparam longint unsigned SPS_WIDTH_CYC = SPS_CLK_HZ * SPS_WIDTH_MS / 1000;
  localparam longint unsigned SPS_COMM_HALF_CYC = SPS_CLK_HZ / (2 * SPS_COMM_HZ);
  localparam longint unsigned SPS_INIT_CYC = SPS_CLK_HZ * SPS_INIT_S;
  localparam longint unsigned SPS_FLASH_CYC = SPS_CLK_HZ * SPS_FLASH_MS / 1000;
  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [1:0] {
    SPS_ST_WAIT_SATS = 2'b00,
    SPS_ST_INIT = 2'b01,
    SPS_ST_RUN = 2'b10
  } sps_state_e;
endpackage

// ==== include/sps_tick_if.sv ====
`timescale 1ns/1ps
interface sps_tick_if;
  logic pulse;
  logic comm_wave;
  logic flash;
  logic restart;
  modport gen (input restart, output pulse, output comm_wave, output flash);
  modport use_side (output restart, input pulse, input comm_wave, input flash);
endinterface

// ==== src/sps_tick_gen.sv ====
`timescale 1ns/1ps
module sps_tick_gen #(
  parameter longint unsigned PERIOD_CYC = sps_pkg::SPS_PERIOD_CYC,
  parameter longint unsigned WIDTH_CYC = sps_pkg::SPS_WIDTH_CYC,
  parameter longint unsigned COMM_HALF_CYC = sps_pkg::SPS_COMM_HALF_CYC,
  parameter longint unsigned FLASH_CYC = sps_pkg::SPS_FLASH_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // ticks
  sps_tick_if.gen tk
);
  import sps_pkg::*;
  logic [31:0] sec_cnt;
  logic [31:0] comm_cnt;
  logic [31:0] flash_cnt;
  // ****************************************
  // one second frame
  // ****************************************
  // [R14] one reference counter
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || tk.restart || sec_cnt == 32'(PERIOD_CYC - 1)) begin
      sec_cnt <= '0;
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end
  // [R1] high for width
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || tk.restart) begin
      tk.pulse <= 1'b0;
    end else begin
      tk.pulse <= sec_cnt < 32'(WIDTH_CYC);
    end
  end
  // ****************************************
  // commissioning wave and flash
  // ****************************************
  // [R11] 250 khz square
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      comm_cnt <= '0;
      tk.comm_wave <= 1'b0;
    end else if (comm_cnt == 32'(COMM_HALF_CYC - 1)) begin
      comm_cnt <= '0;
      tk.comm_wave <= ~tk.comm_wave;
    end else begin
      comm_cnt <= comm_cnt + 32'h1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      flash_cnt <= '0;
      tk.flash <= 1'b1;
    end else if (flash_cnt == 32'(FLASH_CYC - 1)) begin
      flash_cnt <= '0;
      tk.flash <= ~tk.flash;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end
endmodule

// ==== src/sps_sync_out.sv ====
`timescale 1ns/1ps
// How it works
// [R1] while enabled each output pulses once a second, high for 200 ms.
// [R2] four outputs, one per relay, carry the same train.
// [R3] the pulse appears only while at least four satellites are tracked.
// [R4] after power-up and four satellites, a 3 hour wait precedes any output; the antenna-off 250 khz wave still goes out during the wait.
// [R5] the health light is on from power-up and stays steady while healthy.
// [R6] the not-initialised light stays on until initialisation completes.
// [R7] eight count lights show how many satellites are tracked.
// [R8] below four satellites the output is off until the count recovers.
// [R9] once initialised, recovery of count or antenna restarts output at once.
// [R10] power loss (reset) discards the initialised state.
// [R11] with the antenna off the output is a continuous 250 khz wave.
// [R12] in commissioning mode the health light flashes.
// [R13] the relay treats the 250 khz wave as loss of source.
// [R14] all timing comes from counters on the one reference clock.
module sps_sync_out #(
  parameter int unsigned N_OUT = sps_pkg::SPS_N_OUT,
  parameter longint unsigned INIT_CYC = sps_pkg::SPS_INIT_CYC,
  parameter longint unsigned PERIOD_CYC = sps_pkg::SPS_PERIOD_CYC,
  parameter longint unsigned WIDTH_CYC = sps_pkg::SPS_WIDTH_CYC,
  parameter longint unsigned COMM_HALF_CYC = sps_pkg::SPS_COMM_HALF_CYC,
  parameter longint unsigned FLASH_CYC = sps_pkg::SPS_FLASH_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // receiver status pins
  input wire logic [3:0] i_sat_count,
  input wire logic i_antenna_ok,
  input wire logic i_unit_ok,
  // fibre outputs
  output logic [N_OUT-1:0] o_sync,
  // indicators
  output logic o_led_healthy,
  output logic o_led_not_init,
  output logic [sps_pkg::SPS_N_LED-1:0] o_led_count
);
  import sps_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [3:0] sat_meta;
  logic [3:0] sat_sync;
  logic [3:0] sat_prev;
  logic [3:0] sat_cnt;
  logic [1:0] ant_meta;
  logic [1:0] ok_meta;
  logic ant_ok;
  logic unit_ok;
  // count bits may settle on different edges
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sat_meta <= 4'h0;
      sat_sync <= 4'h0;
      sat_prev <= 4'h0;
    end else begin
      sat_meta <= i_sat_count;
      sat_sync <= sat_meta;
      sat_prev <= sat_sync;
    end
  end
  // take a count only when two samples agree, at four cycles of delay
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sat_cnt <= 4'h0;
    end else if (sat_sync == sat_prev) begin
      sat_cnt <= sat_sync;
    end
  end
  // idle high so the lights hold across reset release
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ant_meta <= 2'h3;
      ok_meta <= 2'h3;
    end else begin
      ant_meta <= {ant_meta[0], i_antenna_ok};
      ok_meta <= {ok_meta[0], i_unit_ok};
    end
  end
  assign ant_ok = ant_meta[1];
  assign unit_ok = ok_meta[1];

  function automatic logic enough(input logic [3:0] n);
    return n >= SPS_MIN_SATS;
  endfunction

  // ****************************************
  // initialisation state machine
  // ****************************************
  sps_state_e state;
  sps_state_e next_state;
  logic [47:0] init_cnt;
  logic sats_ok;
  assign sats_ok = enough(sat_cnt);

  always_comb begin
    next_state = state;
    case (state)
      SPS_ST_WAIT_SATS: begin
        // [R4] start the wait
        if (sats_ok && ant_ok) begin
          next_state = SPS_ST_INIT;
        end
      end
      SPS_ST_INIT: begin
        if (!sats_ok || !ant_ok) begin
          next_state = SPS_ST_WAIT_SATS;
        end else if (init_cnt == 48'(INIT_CYC - 1)) begin
          next_state = SPS_ST_RUN;
        end
      end
      // [R9] stays initialised
      SPS_ST_RUN: next_state = SPS_ST_RUN;
      default: next_state = SPS_ST_WAIT_SATS;
    endcase
  end

  // [R10] reset forgets init
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state <= SPS_ST_WAIT_SATS;
    end else begin
      state <= next_state;
    end
  end

  // 48 bits hold the full wait at the reference clock
  // [R14] interval counter
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || state != SPS_ST_INIT || next_state != SPS_ST_INIT) begin
      init_cnt <= '0;
    end else begin
      init_cnt <= init_cnt + 48'h1;
    end
  end

  // ****************************************
  // output gating
  // ****************************************
  sps_tick_if tk ();
  logic out_on;
  logic out_on_d;
  logic comm_mode;
  // [R3] gate on satellites
  // [R8] off below four
  assign out_on = (state == SPS_ST_RUN) && sats_ok && ant_ok;
  // commissioning overrides the pulse in any state
  // [R11] antenna off
  assign comm_mode = !ant_ok;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      out_on_d <= 1'b0;
    end else begin
      out_on_d <= out_on;
    end
  end
  // restart aligns the second frame to the return of output
  // [R9] frame restarts at once on recovery
  assign tk.restart = out_on && !out_on_d;

  sps_tick_gen #(
    .PERIOD_CYC(PERIOD_CYC),
    .WIDTH_CYC(WIDTH_CYC),
    .COMM_HALF_CYC(COMM_HALF_CYC),
    .FLASH_CYC(FLASH_CYC)
  ) u_tick (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .tk(tk)
  );

  // [R2] same train on all
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_sync <= '0;
    end else if (comm_mode) begin
      o_sync <= {N_OUT{tk.comm_wave}};
    end else if (out_on_d) begin
      // [R1] second pulse
      o_sync <= {N_OUT{tk.pulse}};
    end else begin
      o_sync <= '0;
    end
  end

  // ****************************************
  // indicators
  // ****************************************
  // unit health steers the light outside commissioning
  // [R5] steady healthy
  // [R12] flash in commissioning
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_led_healthy <= 1'b1;
    end else if (comm_mode) begin
      o_led_healthy <= tk.flash;
    end else begin
      o_led_healthy <= unit_ok;
    end
  end

  // [R6] lit until initialised
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_led_not_init <= 1'b1;
    end else begin
      o_led_not_init <= !(state == SPS_ST_RUN && sats_ok);
    end
  end

  // counts above eight light the whole bar
  // [R7] count bar, led k lit when count >= k+1
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_led_count <= '0;
    end else begin
      for (int k = 0; k < SPS_N_LED; k++) begin
        o_led_count[k] <= (sat_cnt > 4'(k));
      end
    end
  end
endmodule

// ==== sim/sps_sync_out_asserts.sv ====
`timescale 1ns/1ps
module sps_sync_out_asserts #(
  parameter int N_OUT = 4, INIT_CYC = 50, PERIOD_CYC = 100,
  parameter int WIDTH_CYC = 20, COMM_HALF_CYC = 2, FLASH_CYC = 10
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_sat_count,
  input wire logic i_antenna_ok,
  input wire logic [N_OUT-1:0] o_sync,
  input wire logic o_led_healthy,
  input wire logic o_led_not_init,
  input wire logic [7:0] o_led_count
);
  int ok_cnt, off_cnt, run, hs_cnt;
  logic done;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // ***
  // run lengths seen at the pins
  // ***
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ok_cnt <= 0;
      off_cnt <= 0;
      run <= 0;
      hs_cnt <= 0;
      done <= 1'b0;
    end else begin
      ok_cnt <= (i_antenna_ok && i_sat_count >= 4'h4) ? ok_cnt + 1 : 0;
      off_cnt <= !i_antenna_ok ? off_cnt + 1 : 0;
      run <= $stable(o_sync[0]) ? run + 1 : 0;
      hs_cnt <= $stable(o_led_healthy) ? hs_cnt + 1 : 0;
      // margin covers input filter and state delay
      done <= done || ok_cnt >= INIT_CYC + 6;
    end
  end
  property p_same; o_sync == {N_OUT{o_sync[0]}}; endproperty
  a_same: assert property (p_same) else $error("outputs differ");
  property p_bar; $stable(i_sat_count) [*7] |->
    o_led_count == 8'((16'h1 << i_sat_count) - 16'h1); endproperty
  a_bar: assert property (p_bar) else $error("count bar");
  property p_low; (i_antenna_ok && i_sat_count < 4'h4) [*7] |-> o_sync == '0; endproperty
  a_low: assert property (p_low) else $error("output with few");
  property p_width; $fell(o_sync[0]) && ok_cnt > PERIOD_CYC + 4 |-> run == WIDTH_CYC - 1;
  endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_comm; off_cnt > 8 |-> o_sync[0] != $past(o_sync[0], COMM_HALF_CYC); endproperty
  a_comm: assert property (p_comm) else $error("comm wave");
  property p_flash; off_cnt > 30 |-> hs_cnt < FLASH_CYC; endproperty
  a_flash: assert property (p_flash) else $error("no flash");
  property p_early; !done && ok_cnt > 4 && ok_cnt < INIT_CYC |->
    o_sync == '0 && o_led_not_init; endproperty
  a_early: assert property (p_early) else $error("early output");
  property p_restart; done && ok_cnt == 1 |-> ##[2:8] o_sync[0]; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
endmodule
bind sps_sync_out sps_sync_out_asserts #(.N_OUT(N_OUT), .INIT_CYC(INIT_CYC),
  .PERIOD_CYC(PERIOD_CYC), .WIDTH_CYC(WIDTH_CYC), .COMM_HALF_CYC(COMM_HALF_CYC),
  .FLASH_CYC(FLASH_CYC)) i_chk (.*);

// ==== sim/sps_relay_model.sv ====
`timescale 1ns/1ps
// ***
// relay end of one fibre
// ***
module sps_relay_model #(
  parameter int WIDTH_CYC = 20
) (
  input wire logic i_mclk,
  input wire logic i_sync,
  output int o_pulses = 0,
  output logic o_lost = 1'b0
);
  int run = 0;
  always @(posedge i_mclk) begin
    if (i_sync) begin
      run <= run + 1;
    end else begin
      if (run == WIDTH_CYC) o_pulses <= o_pulses + 1;
      if (run > 0 && run < 4) o_lost <= 1'b1;
      run <= 0;
    end
  end
endmodule

// ==== sim/sps_sync_out_tb.sv ====
`timescale 1ns/1ps
module sps_sync_out_tb;
  import sps_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_sat_count = 4'h0;
  logic i_antenna_ok = 1'b1;
  logic i_unit_ok = 1'b1;
  logic [3:0] o_sync;
  logic o_led_healthy, o_led_not_init, lost;
  logic [7:0] o_led_count;
  logic [3:0] c;
  int pulses, fails = 0, n_tests = 0;
  always #5 i_mclk = ~i_mclk;
  sps_sync_out #(.INIT_CYC(50), .PERIOD_CYC(100), .WIDTH_CYC(20), .COMM_HALF_CYC(2),
    .FLASH_CYC(10)) i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sat_count(i_sat_count),
    .i_antenna_ok(i_antenna_ok), .i_unit_ok(i_unit_ok), .o_sync(o_sync),
    .o_led_healthy(o_led_healthy), .o_led_not_init(o_led_not_init), .o_led_count(o_led_count));
  sps_relay_model #(.WIDTH_CYC(20)) i_relay (.i_mclk(i_mclk), .i_sync(o_sync[3]),
    .o_pulses(pulses), .o_lost(lost));
  // ***
  // helpers
  // ***
  function automatic logic [7:0] bar(input logic [3:0] n);
    return (n >= SPS_MAX_SATS) ? 8'hff : 8'((9'h1 << n) - 9'h1);
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic drive(input int n, input logic [3:0] cnt, input logic ant);
    repeat (n) begin
      @(negedge i_mclk);
      i_sat_count = cnt;
      i_antenna_ok = ant;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h4e2c9292));
    repeat (2) @(negedge i_mclk);
    i_rst_b = 1'b1;
    repeat (30) drive(3, 4'($urandom_range(3, 0)), 1'b1);
    drive(8, 4'h3, 1'b1);
    chk("sync", 8'h0, 8'(o_sync));
    chk("not_init", 8'h1, 8'(o_led_not_init));
    chk("bar", bar(4'h3), o_led_count);
    chk("healthy", 8'h1, 8'(o_led_healthy));
    $display("few_sats done");
    c = 4'($urandom_range(8, 4));
    drive(45, c, 1'b1);
    chk("sync", 8'h0, 8'(o_sync));
    drive(260, c, 1'b1);
    chk("pulses", 8'h3, 8'(pulses));
    chk("not_init", 8'h0, 8'(o_led_not_init));
    chk("bar", bar(c), o_led_count);
    $display("init done");
    drive(20, 4'h3, 1'b1);
    chk("sync", 8'h0, 8'(o_sync));
    drive(12, 4'h4, 1'b1);
    chk("sync", 8'hf, 8'(o_sync));
    chk("lost", 8'h0, 8'(lost));
    $display("recover done");
    drive(100, c, 1'b0);
    chk("lost", 8'h1, 8'(lost));
    drive(12, c, 1'b1);
    chk("sync", 8'hf, 8'(o_sync));
    $display("commission done");
    i_unit_ok = 1'b0;
    drive(4, c, 1'b1);
    chk("healthy", 8'h0, 8'(o_led_healthy));
    i_unit_ok = 1'b1;
    $display("unit_fault done");
    i_rst_b = 1'b0;
    drive(2, 4'h8, 1'b1);
    i_rst_b = 1'b1;
    drive(40, 4'h8, 1'b1);
    chk("sync", 8'h0, 8'(o_sync));
    chk("not_init", 8'h1, 8'(o_led_not_init));
    chk("healthy", 8'h1, 8'(o_led_healthy));
    $display("power_loss done");
    complete_run();
  end
  initial begin
    #20000;
    fails++;
    complete_run();
  end
endmodule
